// ===== core/tfm_decoder.v
/*
 * Memory-mapped task-file decoder: decodes common-memory cycles from the
 * card pins onto the task-file registers and the data register stream.
 * Assumes host pins are asynchronous to clk and hold each strobe for at
 * least four clock periods; the core supplies status and the read stream.
 */
`timescale 1ns/10ps
`include "tfm_defs.vh"

module tfm_decoder (
    input  wire        clk,                     // System clock, 40 MHz
    input  wire        rst,                     // Asynchronous reset, active high
    input  wire        attribute_select_n,      // Register select pin, high for common memory
    input  wire        low_byte_chip_enable_n,  // Low byte chip enable pin
    input  wire        high_byte_chip_enable_n, // High byte chip enable pin
    input  wire        output_enable_n,         // Read strobe pin
    input  wire        write_enable_n,          // Write strobe pin
    input  wire [10:0] address,                 // Address pins, bit 10 selects window
    input  wire [15:0] data_in,                 // Data bus input
    output reg  [15:0] data_out,                // Data bus output
    output wire        data_low_oe_n,           // Low lane drive enable, low drives
    output wire        data_high_oe_n,          // High lane drive enable, low drives
    input  wire [1:0]  config_index,            // Configuration index from core
    input  wire [7:0]  error_code,              // Error register contents
    input  wire [7:0]  status_code,             // Status and alt status contents
    input  wire [7:0]  drive_address,           // Drive address register contents
    input  wire [15:0] rd_word,                 // Head of the read data stream
    output wire        rd_pop,                  // Pulse: read word consumed
    output wire [15:0] wr_word,                 // Written data word
    output wire        wr_push,                 // Pulse: write word complete
    output reg  [7:0]  feature,                 // Feature register
    output reg  [7:0]  sector_count,            // Sector count register
    output reg  [7:0]  sector_number,           // Sector number register
    output reg  [7:0]  cylinder_low,            // Cylinder low register
    output reg  [7:0]  cylinder_high,           // Cylinder high register
    output reg  [7:0]  card_head_select,        // Card/head select register
    output reg  [7:0]  command,                 // Last command written
    output reg         command_strobe,          // Pulse: command written
    output reg  [7:0]  device_control           // Device control register
);

    // ****************************************************************
    // Helpers
    // ****************************************************************
    // Effective offset: upper window folds to 8/9, high-only byte names odd reg
    function [3:0] eff_offset;
        input [10:0] a;
        input        ce1n;
        input        ce2n;
        begin
            if (a[10]) begin
                eff_offset = a[0] ? `TFM_OFF_DUP_ODD : `TFM_OFF_DUP_EVEN;
            end else if (ce1n & ~ce2n) begin
                eff_offset = {a[3:1], 1'b1};
            end else begin
                eff_offset = a[3:0];
            end
        end
    endfunction

    function is_data;
        input [3:0] off;
        begin
            is_data = (off == `TFM_OFF_EVEN_DATA) || (off == `TFM_OFF_DUP_EVEN) ||
                      (off == `TFM_OFF_DUP_ODD);
        end
    endfunction

    // ****************************************************************
    // Pin synchronisation
    // ****************************************************************
    wire [4:0]  ctl_s;
    wire [10:0] addr_s;
    wire [15:0] din_s;

    tfm_sync #(.W(5)) u_sync_ctl (
        .clk      (clk),
        .rst      (rst),
        .async_in ({attribute_select_n, low_byte_chip_enable_n, high_byte_chip_enable_n,
                    output_enable_n, write_enable_n}),
        .init_val (5'h1F),
        .sync_out (ctl_s)
    );

    tfm_sync #(.W(11)) u_sync_addr (
        .clk      (clk),
        .rst      (rst),
        .async_in (address),
        .init_val (11'h7FF),
        .sync_out (addr_s)
    );

    tfm_sync #(.W(16)) u_sync_data (
        .clk      (clk),
        .rst      (rst),
        .async_in (data_in),
        .init_val (16'hFFFF),
        .sync_out (din_s)
    );

    wire attr_s = ctl_s[4];
    wire ce1n_s = ctl_s[3];
    wire ce2n_s = ctl_s[2];
    wire oen_s  = ctl_s[1];
    wire wen_s  = ctl_s[0];

    // Only index 0 maps the task file into common memory
    wire selected = attr_s & (config_index == `TFM_CFG_MEMORY) &
                    ~(ce1n_s & ce2n_s);
    wire word_cyc = ~ce1n_s & ~ce2n_s;
    wire hi_only  = ce1n_s & ~ce2n_s;
    wire [3:0] off_now = eff_offset(addr_s, ce1n_s, ce2n_s);

    // ****************************************************************
    // Strobe edges; 100 ns strobes still span several clocks
    // ****************************************************************
    reg        oen_d;
    reg        wen_d;
    reg        wr_sel_q;
    reg [3:0]  wr_off_q;
    reg        wr_word_q;
    reg        wr_hi_q;
    reg [15:0] wr_data_q;

    wire rd_start = selected & oen_d & ~oen_s & wen_s;
    wire wr_end   = wr_sel_q & ~wen_d & wen_s;

    // Write address and data are captured while the strobe is low and
    // committed on its rising edge, when the host guarantees setup
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            oen_d     <= 1'b1;
            wen_d     <= 1'b1;
            wr_sel_q  <= 1'b0;
            wr_off_q  <= 4'h0;
            wr_word_q <= 1'b0;
            wr_hi_q   <= 1'b0;
            wr_data_q <= 16'h0000;
        end else begin
            oen_d <= oen_s;
            wen_d <= wen_s;
            if (~wen_s) begin
                wr_sel_q  <= selected;
                wr_off_q  <= off_now;
                wr_word_q <= word_cyc;
                wr_hi_q   <= hi_only;
                wr_data_q <= din_s;
            end else if (wr_end) begin
                wr_sel_q <= 1'b0;
            end
        end
    end

    // ****************************************************************
    // Data stream
    // ****************************************************************
    wire        rd_is_data = rd_start & is_data(off_now);
    wire        wr_is_data = wr_end & is_data(wr_off_q);
    wire        dp_access  = rd_is_data | wr_is_data;
    wire        dp_word    = wr_end ? wr_word_q : word_cyc;
    wire [3:0]  dp_off     = wr_end ? wr_off_q : off_now;
    wire [15:0] dp_wdata   = wr_hi_q ? {8'h00, wr_data_q[15:8]} : wr_data_q;
    wire [15:0] dp_rdata;

    tfm_data_port u_data_port (
        .clk        (clk),
        .rst        (rst),
        .access     (dp_access),
        .is_write   (wr_end),
        .word_acc   (dp_word),
        .odd_acc    (dp_off == `TFM_OFF_DUP_ODD),
        .host_wdata (dp_wdata),
        .rd_word    (rd_word),
        .rdata      (dp_rdata),
        .rd_pop     (rd_pop),
        .wr_word    (wr_word),
        .wr_push    (wr_push)
    );

    // ****************************************************************
    // Task-file read mux
    // ****************************************************************
    reg [7:0] rd_byte_a;
    reg [7:0] rd_byte_b;

    function [7:0] tf_read;
        input [3:0] off;
        input [7:0] err;
        input [7:0] stat;
        input [7:0] drv;
        input [7:0] sc;
        input [7:0] sn;
        input [7:0] cl;
        input [7:0] ch;
        input [7:0] hd;
        begin
            case (off)
                `TFM_OFF_ERR_FEAT, `TFM_OFF_DUP_ERR_FEAT: tf_read = err;
                `TFM_OFF_SECTOR_COUNT:  tf_read = sc;
                `TFM_OFF_SECTOR_NUMBER: tf_read = sn;
                `TFM_OFF_CYL_LOW:       tf_read = cl;
                `TFM_OFF_CYL_HIGH:      tf_read = ch;
                `TFM_OFF_CARD_HEAD:     tf_read = hd;
                `TFM_OFF_STAT_CMD, `TFM_OFF_ALT_DEVCTL: tf_read = stat;
                `TFM_OFF_DRIVE_ADDR:    tf_read = drv;
                default:                tf_read = `TFM_UNDEF_READ;
            endcase
        end
    endfunction

    // Word reads of byte registers pair the even register low, odd high
    always @* begin
        rd_byte_a = tf_read({off_now[3:1], 1'b0}, error_code, status_code, drive_address,
                            sector_count, sector_number, cylinder_low, cylinder_high,
                            card_head_select);
        rd_byte_b = tf_read(off_now, error_code, status_code, drive_address,
                            sector_count, sector_number, cylinder_low, cylinder_high,
                            card_head_select);
    end

    always @(posedge clk or posedge rst) begin
        if (rst) begin
            data_out <= 16'h0000;
        end else if (rd_start) begin
            if (is_data(off_now)) begin
                if (hi_only) begin
                    data_out <= {dp_rdata[7:0], 8'h00};
                end else begin
                    data_out <= dp_rdata;
                end
            end else if (word_cyc) begin
                data_out <= {tf_read({off_now[3:1], 1'b1}, error_code, status_code,
                                     drive_address, sector_count, sector_number,
                                     cylinder_low, cylinder_high, card_head_select),
                             rd_byte_a};
            end else if (hi_only) begin
                data_out <= {rd_byte_b, 8'h00};
            end else begin
                data_out <= {8'h00, rd_byte_b};
            end
        end
    end

    // Lanes driven only while a selected read strobe is low
    wire drive = selected & ~oen_s & ~oen_d;
    assign data_low_oe_n  = ~(drive & ~ce1n_s);
    assign data_high_oe_n = ~(drive & ~ce2n_s);

    // ****************************************************************
    // Task-file writes
    // ****************************************************************
    function [7:0] wr_lane;
        input [3:0]  off;
        input        word;
        input        hi;
        input [15:0] d;
        begin
            if (hi | (word & off[0])) begin
                wr_lane = d[15:8];
            end else begin
                wr_lane = d[7:0];
            end
        end
    endfunction

    wire       wr_reg = wr_end & ~is_data(wr_off_q);
    wire [7:0] wb_lo  = wr_data_q[7:0];
    wire [7:0] wb     = wr_lane(wr_off_q, 1'b0, wr_hi_q, wr_data_q);

    always @(posedge clk or posedge rst) begin
        if (rst) begin
            feature          <= `TFM_REG_RESET;
            sector_count     <= `TFM_REG_RESET;
            sector_number    <= `TFM_REG_RESET;
            cylinder_low     <= `TFM_REG_RESET;
            cylinder_high    <= `TFM_REG_RESET;
            card_head_select <= `TFM_REG_RESET;
            command          <= `TFM_REG_RESET;
            command_strobe   <= 1'b0;
            device_control   <= `TFM_REG_RESET;
        end else begin
            command_strobe <= 1'b0;
            if (wr_reg) begin
                // A word write to even register 2, 4 or 6 also writes its odd partner
                case ({wr_word_q, wr_off_q})
                    {1'b0, `TFM_OFF_ERR_FEAT}, {1'b0, `TFM_OFF_DUP_ERR_FEAT}: feature <= wb;
                    {1'b1, `TFM_OFF_ERR_FEAT}, {1'b1, `TFM_OFF_DUP_ERR_FEAT}: feature <= wb_lo;
                    {1'b0, `TFM_OFF_SECTOR_COUNT}:  sector_count  <= wb;
                    {1'b0, `TFM_OFF_SECTOR_NUMBER}: sector_number <= wb;
                    {1'b1, `TFM_OFF_SECTOR_COUNT}, {1'b1, `TFM_OFF_SECTOR_NUMBER}: begin
                        sector_count  <= wb_lo;
                        sector_number <= wr_data_q[15:8];
                    end
                    {1'b0, `TFM_OFF_CYL_LOW}:  cylinder_low  <= wb;
                    {1'b0, `TFM_OFF_CYL_HIGH}: cylinder_high <= wb;
                    {1'b1, `TFM_OFF_CYL_LOW}, {1'b1, `TFM_OFF_CYL_HIGH}: begin
                        cylinder_low  <= wb_lo;
                        cylinder_high <= wr_data_q[15:8];
                    end
                    {1'b0, `TFM_OFF_CARD_HEAD}: card_head_select <= wb;
                    {1'b0, `TFM_OFF_STAT_CMD}: begin
                        command        <= wb;
                        command_strobe <= 1'b1;
                    end
                    {1'b1, `TFM_OFF_CARD_HEAD}, {1'b1, `TFM_OFF_STAT_CMD}: begin
                        card_head_select <= wb_lo;
                        command          <= wr_data_q[15:8];
                        command_strobe   <= 1'b1;
                    end
                    {1'b0, `TFM_OFF_ALT_DEVCTL}, {1'b1, `TFM_OFF_ALT_DEVCTL},
                    {1'b1, `TFM_OFF_DRIVE_ADDR}: device_control <= wb_lo;
                    default: ;
                endcase
            end
        end
    end

endmodule // tfm_decoder

// ===== core/tfm_defs.vh
/*
 * Constants for the memory-mapped task-file decoder: offsets, configuration
 * index, read filler and timing counts.
 * Assumes inclusion by bare name from the decoder files; defines only.
 */
`ifndef TFM_DEFS_VH
`define TFM_DEFS_VH

// ****************************************************************
// Task-file offsets (address bits 3..0)
// ****************************************************************
`define TFM_OFF_EVEN_DATA      4'h0
`define TFM_OFF_ERR_FEAT       4'h1
`define TFM_OFF_SECTOR_COUNT   4'h2
`define TFM_OFF_SECTOR_NUMBER  4'h3
`define TFM_OFF_CYL_LOW        4'h4
`define TFM_OFF_CYL_HIGH       4'h5
`define TFM_OFF_CARD_HEAD      4'h6
`define TFM_OFF_STAT_CMD       4'h7
`define TFM_OFF_DUP_EVEN       4'h8
`define TFM_OFF_DUP_ODD        4'h9
`define TFM_OFF_DUP_ERR_FEAT   4'hD
`define TFM_OFF_ALT_DEVCTL     4'hE
`define TFM_OFF_DRIVE_ADDR     4'hF

// ****************************************************************
// Configuration and values
// ****************************************************************
`define TFM_CFG_MEMORY         2'h0
`define TFM_CFG_CONTIG_IO      2'h1
`define TFM_CFG_PRIMARY_IO     2'h2
`define TFM_CFG_SECONDARY_IO   2'h3
`define TFM_UNDEF_READ         8'hFF
`define TFM_REG_RESET          8'h00

// ****************************************************************
// Timing
// ****************************************************************
`define TFM_CLK_PERIOD_NS      25
`define TFM_ADV_CYCLE_NS       100
`define TFM_ADV_CYCLE_CLKS     (`TFM_ADV_CYCLE_NS / `TFM_CLK_PERIOD_NS)
`define TFM_SYNC_STAGES        2

`endif

// ===== core/tfm_sync.v
/*
 * Two-stage synchroniser for a vector of pin levels.
 * Assumes each bit is a level that is stable for several clock periods.
 */
`timescale 1ns/10ps

module tfm_sync #(
    parameter W = 1
) (
    input  wire         clk,     // System clock
    input  wire         rst,     // Asynchronous reset, active high
    input  wire [W-1:0] async_in,// Pin levels
    input  wire [W-1:0] init_val,// Unused level after reset, constant at top
    output reg  [W-1:0] sync_out // Synchronised levels
);

    reg [W-1:0] stage1;

    // ****************************************************************
    // Two flip-flops; only the second stage is read outside
    // ****************************************************************
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            stage1   <= {W{1'b1}};
            sync_out <= {W{1'b1}};
        end else begin
            stage1   <= async_in | (init_val & {W{1'b0}});
            sync_out <= stage1;
        end
    end

endmodule // tfm_sync

// ===== core/tfm_data_port.v
/*
 * Byte and word pairing for the data register stream.
 * Assumes one access pulse per host cycle and a core-side word stream
 * whose head is always presented on rd_word.
 */
`timescale 1ns/10ps

module tfm_data_port (
    input  wire        clk,        // System clock
    input  wire        rst,        // Asynchronous reset, active high
    input  wire        access,     // One-cycle pulse per data access
    input  wire        is_write,   // Access is a write
    input  wire        word_acc,   // Sixteen-bit access
    input  wire        odd_acc,    // Byte access that names the odd byte
    input  wire [15:0] host_wdata, // Write data, byte in low lane for bytes
    input  wire [15:0] rd_word,    // Head word of the read stream
    output wire [15:0] rdata,      // Read data, byte in low lane for bytes
    output reg         rd_pop,     // Pulse: read word consumed
    output reg  [15:0] wr_word,    // Assembled write word
    output reg         wr_push     // Pulse: write word complete
);

    reg        even_done;
    reg        odd_done;
    reg  [7:0] even_hold;
    wire       pick_odd;
    wire       completes;

    // Repeated byte to 0/8 moves on to the odd byte once the even one is gone
    assign pick_odd  = odd_acc | even_done;
    assign completes = word_acc | (pick_odd ? even_done : odd_done);
    assign rdata     = word_acc ? rd_word :
                       (pick_odd ? {8'h00, rd_word[15:8]} : {8'h00, rd_word[7:0]});

    // ****************************************************************
    // Lane tracking, pop and push
    // ****************************************************************
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            even_done <= 1'b0;
            odd_done  <= 1'b0;
            even_hold <= 8'h00;
            rd_pop    <= 1'b0;
            wr_word   <= 16'h0000;
            wr_push   <= 1'b0;
        end else begin
            rd_pop  <= 1'b0;
            wr_push <= 1'b0;
            if (access) begin
                if (completes) begin
                    even_done <= 1'b0;
                    odd_done  <= 1'b0;
                    rd_pop    <= ~is_write;
                    wr_push   <= is_write;
                    if (word_acc) begin
                        wr_word <= host_wdata;
                    end else if (pick_odd) begin
                        wr_word <= {host_wdata[7:0], even_hold};
                    end else begin
                        wr_word <= {wr_word[15:8], host_wdata[7:0]};
                    end
                end else if (pick_odd) begin
                    odd_done <= 1'b1;
                    wr_word  <= {host_wdata[7:0], wr_word[7:0]};
                end else begin
                    even_done <= 1'b1;
                    even_hold <= host_wdata[7:0];
                end
            end
        end
    end

endmodule // tfm_data_port

// ===== tb/tfm_decoder_monitor.sv
/* Timing checks on the decoder's pins and pulses.
   Assumes host pins change just after a rising edge of clk. */
`timescale 1ns/10ps
module tfm_decoder_monitor (
    input wire       clk,                     // Clock
    input wire       rst,                     // Reset
    input wire       attribute_select_n,      // Register select
    input wire       low_byte_chip_enable_n,  // Low enable
    input wire       output_enable_n,         // Read strobe
    input wire       write_enable_n,          // Write strobe
    input wire [1:0] config_index,            // Mapping
    input wire       data_low_oe_n,           // Low lane drive
    input wire       data_high_oe_n,          // High lane drive
    input wire       rd_pop,                  // Read pop
    input wire       wr_push,                 // Write push
    input wire       command_strobe           // Command pulse
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    a_pop_single: assert property (rd_pop |=> !rd_pop) else $error("pop too long");
    a_pop_after_read: assert property (rd_pop |-> !$past(output_enable_n, 2))
        else $error("pop without read");
    a_push_after_write: assert property (wr_push |-> !$past(write_enable_n, 4))
        else $error("push without write");
    a_push_single: assert property (wr_push |=> !wr_push) else $error("push too long");
    a_cmd_single: assert property (command_strobe |=> !command_strobe)
        else $error("command pulse too long");
    a_attr_refuse: assert property (!attribute_select_n && !$past(attribute_select_n, 3)
        |-> data_low_oe_n && data_high_oe_n) else $error("drive in attribute space");
    a_cfg_refuse: assert property (config_index != 2'h0 && $past(config_index, 3) != 2'h0
        |-> data_low_oe_n && data_high_oe_n) else $error("drive in io mapping");
    a_idle_release: assert property (output_enable_n && $past(output_enable_n, 3)
        |-> data_low_oe_n && data_high_oe_n) else $error("drive without read");
    a_high_only: assert property (low_byte_chip_enable_n && $past(low_byte_chip_enable_n, 3)
        |-> data_low_oe_n) else $error("low lane driven");
endmodule // tfm_decoder_monitor
bind tfm_decoder tfm_decoder_monitor mon (.clk(clk), .rst(rst),
    .attribute_select_n(attribute_select_n), .low_byte_chip_enable_n(low_byte_chip_enable_n),
    .output_enable_n(output_enable_n), .write_enable_n(write_enable_n),
    .config_index(config_index), .data_low_oe_n(data_low_oe_n), .data_high_oe_n(data_high_oe_n),
    .rd_pop(rd_pop), .wr_push(wr_push), .command_strobe(command_strobe));

// ===== tb/tfm_stream_model.sv
/* Sector buffer model: presents consecutive words, advancing on each pop.
   Assumes rd_pop is a one-cycle pulse in the clk domain. */
`timescale 1ns/10ps
module tfm_stream_model (
    input  wire        clk,     // Clock
    input  wire        rst,     // Reset
    input  wire        rd_pop,  // Word consumed
    output reg  [15:0] rd_word  // Head word
);
    always @(posedge clk or posedge rst) begin
        if (rst) rd_word <= 16'hA000;
        else if (rd_pop) rd_word <= rd_word + 16'h0001;
    end
endmodule // tfm_stream_model

// ===== tb/tb_top.sv
/* Self-checking bench for the memory-mapped decoder.
   Assumes the stream model starts at A000 and steps by one per pop. */
`timescale 1ns/10ps
module tb_top;
    reg         clk = 0, rst = 1, attr_n = 1, cel_n = 1, ceh_n = 1, oe_n = 1, we_n = 1;
    reg  [10:0] addr = 11'h000;
    reg  [15:0] din = 16'h0000, r, q;
    reg  [1:0]  cfg = 2'h0;
    wire [15:0] dout, rd_word, wr_word;
    wire        lo_n, hi_n, rd_pop, wr_push, stb;
    wire [7:0]  feat, sc, sn, cl, ch, hd, cmd, dctl;
    reg  [1:0]  ln;
    integer     n_fail = 0, checked = 0, cycles = 0, n_push = 0, n_cmd = 0;
    tfm_decoder dut (.clk(clk), .rst(rst), .attribute_select_n(attr_n),
        .low_byte_chip_enable_n(cel_n), .high_byte_chip_enable_n(ceh_n),
        .output_enable_n(oe_n), .write_enable_n(we_n), .address(addr), .data_in(din),
        .data_out(dout), .data_low_oe_n(lo_n), .data_high_oe_n(hi_n), .config_index(cfg),
        .error_code(8'hE5), .status_code(8'h50), .drive_address(8'hD3), .rd_word(rd_word),
        .rd_pop(rd_pop), .wr_word(wr_word), .wr_push(wr_push), .feature(feat),
        .sector_count(sc), .sector_number(sn), .cylinder_low(cl), .cylinder_high(ch),
        .card_head_select(hd), .command(cmd), .command_strobe(stb), .device_control(dctl));
    tfm_stream_model model (.clk(clk), .rst(rst), .rd_pop(rd_pop), .rd_word(rd_word));
    initial forever #12.5 clk = ~clk;
    always @(posedge clk) begin
        cycles = cycles + 1;
        n_push = n_push + wr_push;
        n_cmd = n_cmd + stb;
        if (cycles == 5000) begin
            n_fail = n_fail + 1;
            end_sim;
        end
    end
    task end_sim;
        begin
            if (n_fail == 0 && checked > 0) $display("STATUS OK");
            else $display("STATUS NOT OK");
            $finish;
        end
    endtask
    task chk(input [15:0] got, input [15:0] exp);
        begin
            checked = checked + 1;
            if (got !== exp) begin
                n_fail = n_fail + 1;
                $display("unexpected at %0t: got %h expected %h", $time, got, exp);
            end
        end
    endtask
    task step(input integer n);
        begin
            repeat (n) @(posedge clk);
            #2;
        end
    endtask
    task rd(input l, input h, input [10:0] a, output [15:0] d);
        begin
            cel_n = l; ceh_n = h; addr = a; step(1);
            oe_n = 0; step(7);
            d = dout; ln = {lo_n, hi_n}; oe_n = 1; cel_n = 1; ceh_n = 1; step(6);
        end
    endtask
    task wr(input l, input h, input [10:0] a, input [15:0] v);
        begin
            cel_n = l; ceh_n = h; addr = a; din = v; step(1);
            we_n = 0; step(6);
            we_n = 1; step(3);
            cel_n = 1; ceh_n = 1; step(6);
        end
    endtask
    task rb(input [10:0] a, input [7:0] e);
        begin
            rd(1'b0, 1'b1, a, r);
            chk({8'h00, r[7:0]}, {8'h00, e});
        end
    endtask
    initial begin
        step(20);
        rst = 0; step(4);
        chk({sc, feat}, 16'h0000);
        rd(0, 0, 11'h000, r); chk(r, 16'hA000);
        chk({14'h0000, ln}, 16'h0000);
        rd(0, 0, 11'h008, r); chk(r, 16'hA001);
        rd(0, 0, 11'h009, r); chk(r, 16'hA002);
        rd(0, 1, 11'h000, r); rd(0, 1, 11'h000, q); chk({q[7:0], r[7:0]}, 16'hA003);
        rd(0, 1, 11'h009, r);
        rd(0, 1, 11'h008, q); chk({r[7:0], q[7:0]}, 16'hA004);
        rd(0, 1, 11'h008, r); rd(0, 1, 11'h009, q); chk({q[7:0], r[7:0]}, 16'hA005);
        rd(0, 1, 11'h7FE, r); rd(0, 1, 11'h7FF, q); chk({q[7:0], r[7:0]}, 16'hA006);
        rd(1, 0, 11'h000, r); chk({8'h00, r[15:8]}, 16'h00E5);
        chk({14'h0000, ln}, 16'h0002);
        rb(11'h001, 8'hE5);
        chk({14'h0000, ln}, 16'h0001);
        rb(11'h00D, 8'hE5);
        rb(11'h007, 8'h50);
        rb(11'h00E, 8'h50);
        rb(11'h00F, 8'hD3);
        rb(11'h00A, 8'hFF);
        wr(0, 1, 11'h002, 16'h005A); rb(11'h002, 8'h5A);
        wr(0, 1, 11'h00B, 16'h00FF); chk({8'h00, sc}, 16'h005A);
        wr(1, 0, 11'h000, 16'hC300); chk({8'h00, feat}, 16'h00C3);
        wr(0, 1, 11'h00D, 16'h003C); chk({8'h00, feat}, 16'h003C);
        wr(0, 1, 11'h007, 16'h00EC); chk({8'h00, cmd}, 16'h00EC);
        wr(0, 1, 11'h003, 16'h0011); chk({8'h00, sn}, 16'h0011);
        wr(0, 0, 11'h004, 16'h9A78); chk({ch, cl}, 16'h9A78);
        wr(0, 1, 11'h006, 16'h00A0); chk({8'h00, hd}, 16'h00A0);
        wr(0, 1, 11'h00E, 16'h0002); chk({8'h00, dctl}, 16'h0002);
        wr(0, 1, 11'h00F, 16'h00FF); chk({8'h00, dctl}, 16'h0002);
        wr(0, 0, 11'h000, 16'h1234); chk(wr_word, 16'h1234);
        wr(0, 1, 11'h008, 16'h0056); wr(0, 1, 11'h009, 16'h0078); chk(wr_word, 16'h7856);
        cfg = 2'h1; rd(0, 0, 11'h000, r); cfg = 2'h0; chk({14'h0000, ln}, 16'h0003);
        attr_n = 0; rd(0, 0, 11'h000, r); attr_n = 1; chk({14'h0000, ln}, 16'h0003);
        rd(0, 0, 11'h000, r); chk(r, 16'hA007);
        chk(n_push[15:0], 16'h0002);
        chk(n_cmd[15:0], 16'h0001);
        end_sim;
    end
endmodule // tb_top
